// ===== src/battery_backed_clock_ram_port.sv
// Byte-wide battery-backed RAM port with calendar clock bytes at the top of the map
`timescale 1ns/1ps
`include "rtc_ram_map.svh"

// Function
// - Strobe low, select A low, B high: write.
// - Write starts at last of three edges.
// - Write ends at first releasing edge.
// - Falling strobe turns driven outputs off.
// - Deselect window blocks writes, ignores inputs.
// - Supply loss mid-write drops the write; no byte changes.
// - Alert at trip, deselect after timed delay.
// - Writes blocked until threshold plus restore delay.
// - Snapshot hold freezes clock bytes while set.
// - Freezing bytes leaves the counters running.
// - Bytes refresh together; freeze waits for update.
// - Refresh resumes within a second of release.
// - Load hold also freezes bytes for setting.
// - Releasing load hold copies bytes into counters.
// - Packed BCD, 24-hour, documented field ranges.
// - Top eight bytes are clock; rest plain RAM.
// - Unfrozen bytes refresh from counters each second.
// - Control low bits calibration, sixth bit sign.
// - Seconds top bit halts the oscillator.
module battery_backed_clock_ram_port #(
  parameter int unsigned SECOND_CYCLES  = `CLK_HZ,
  parameter int unsigned RESTORE_CYCLES = `RESTORE_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [12:0] addr,
  input  wire logic [7:0]  dataIn,
  output      logic [7:0]  dataOut,
  output      logic        dataOe_n,
  input  wire logic        chipSelectA_n,
  input  wire logic        chipSelectB,
  input  wire logic        outputDrive_n,
  input  wire logic        storeStrobe_n,
  input  wire logic        supplyBelowTrip,
  output      logic        powerFailAlertOut,
  output      logic        powerFailAlertOe_n
);

  localparam int unsigned ALERT_CYCLES = `ALERT_DELAY_CYCLES;

  rtc_ram_pkg::state_s st;
  rtc_ram_pkg::state_s next_st;
  logic [1:0]          rstSync;
  logic                rstn;
  logic [7:0]          mem [0:8191];
  logic                memWe;
  logic                deselected;
  logic                selected;
  logic                writeCond;
  logic                tick;
  logic                frozen;
  logic                isClockAddr;
  logic                loadRelease;

  // Wrapping BCD increment: returns {carry, value}
  function automatic logic [8:0] bcdInc(input logic [7:0] v, input logic [7:0] maxV,
                                        input logic [7:0] minV);
    logic [8:0] r;
    r = {1'b0, v};
    if (v >= maxV) begin
      r = {1'b1, minV};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Last date of a month, leap years every fourth year
  function automatic logic [7:0] monthEnd(input logic [7:0] month, input logic [7:0] year);
    logic leap;
    logic [7:0] r;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    case (month)
      8'h02: begin
        r = leap ? 8'h29 : 8'h28;
      end
      8'h04, 8'h06, 8'h09, 8'h11: begin
        r = 8'h30;
      end
      default: begin
        r = 8'h31;
      end
    endcase
    return r;
  endfunction

  // Counter image of a clock byte with its control bits stripped
  function automatic logic [7:0] timeField(input logic [7:0] b, input int idx);
    logic [7:0] r;
    case (idx)
      0: begin
        r = {1'b0, b[6:0]};
      end
      3: begin
        r = {5'h00, b[2:0]};
      end
      default: begin
        r = b;
      end
    endcase
    return r;
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  assign deselected  = (st.pwr == rtc_ram_pkg::PWR_DESEL) || (st.pwr == rtc_ram_pkg::PWR_RESTORE);
  assign selected    = !deselected && !chipSelectA_n && chipSelectB;
  assign writeCond   = selected && !storeStrobe_n;
  assign isClockAddr = (addr >= `CLOCK_CONTROL);
  assign frozen      = st.clockBytes[0][`CTRL_SNAP_HOLD_BIT] || st.clockBytes[0][`CTRL_LOAD_HOLD_BIT];
  assign tick        = !st.clockBytes[1][`SEC_OSC_HALT_BIT] && (st.prescale == SECOND_CYCLES - 1);
  assign loadRelease = st.prevLoadHold && !st.clockBytes[0][`CTRL_LOAD_HOLD_BIT];

  always_comb begin
    logic [8:0] inc;
    logic       carry;
    int         i;
    inc     = 9'h000;
    carry   = 1'b0;
    i       = 0;
    next_st = st;
    memWe   = 1'b0;

    // Power-fail sequencing
    case (st.pwr)
      rtc_ram_pkg::PWR_OK: begin
        next_st.pwrTimer = 32'h0;
        if (supplyBelowTrip) begin
          next_st.pwr = rtc_ram_pkg::PWR_ALERT;
        end
      end
      rtc_ram_pkg::PWR_ALERT: begin
        next_st.pwrTimer = st.pwrTimer + 32'h1;
        if (!supplyBelowTrip) begin
          next_st.pwr = rtc_ram_pkg::PWR_OK;
        end else if (st.pwrTimer == ALERT_CYCLES - 1) begin
          next_st.pwr = rtc_ram_pkg::PWR_DESEL;
        end
      end
      rtc_ram_pkg::PWR_DESEL: begin
        next_st.pwrTimer = 32'h0;
        if (!supplyBelowTrip) begin
          next_st.pwr = rtc_ram_pkg::PWR_RESTORE;
        end
      end
      rtc_ram_pkg::PWR_RESTORE: begin
        next_st.pwrTimer = st.pwrTimer + 32'h1;
        if (supplyBelowTrip) begin
          next_st.pwr      = rtc_ram_pkg::PWR_DESEL;
          next_st.pwrTimer = 32'h0;
        end else if (st.pwrTimer == RESTORE_CYCLES - 1) begin
          next_st.pwr = rtc_ram_pkg::PWR_OK;
        end
      end
      default: begin
        next_st.pwr = rtc_ram_pkg::PWR_DESEL;
      end
    endcase
    next_st.alertLow = supplyBelowTrip;

    // Timekeeping counters run whether or not the visible bytes are frozen, unless the seconds halt bit is set
    if (st.clockBytes[1][`SEC_OSC_HALT_BIT]) begin
      next_st.prescale = 32'h0;
    end else if (tick) begin
      next_st.prescale = 32'h0;
    end else begin
      next_st.prescale = st.prescale + 32'h1;
    end
    if (tick) begin
      inc = bcdInc(st.counters[0], `MAX_SECONDS, `MIN_ZERO);
      next_st.counters[0] = inc[7:0];
      carry = inc[8];
      if (carry) begin
        inc = bcdInc(st.counters[1], `MAX_MINUTES, `MIN_ZERO);
        next_st.counters[1] = inc[7:0];
        carry = inc[8];
      end
      if (carry) begin
        inc = bcdInc(st.counters[2], `MAX_HOURS, `MIN_ZERO);
        next_st.counters[2] = inc[7:0];
        carry = inc[8];
      end
      if (carry) begin
        inc = bcdInc(st.counters[3], `MAX_WEEKDAY, `MIN_ONE);
        next_st.counters[3] = inc[7:0];
        inc = bcdInc(st.counters[4], monthEnd(st.counters[5], st.counters[6]), `MIN_ONE);
        next_st.counters[4] = inc[7:0];
        carry = inc[8];
      end
      if (carry) begin
        inc = bcdInc(st.counters[5], `MAX_MONTH, `MIN_ONE);
        next_st.counters[5] = inc[7:0];
        carry = inc[8];
      end
      if (carry) begin
        inc = bcdInc(st.counters[6], `MAX_YEAR, `MIN_ZERO);
        next_st.counters[6] = inc[7:0];
      end
    end

    // Whole-set refresh in one cycle; a freeze written now acts from the next cycle
    // The load cycle skips the refresh so stale counts cannot overwrite the new time
    if (tick && !frozen && !loadRelease) begin
      for (i = 0; i < 7; i++) begin
        next_st.clockBytes[i+1] = next_st.counters[i];
      end
      next_st.clockBytes[1][`SEC_OSC_HALT_BIT]  = st.clockBytes[1][`SEC_OSC_HALT_BIT];
      next_st.clockBytes[4][`DAY_FREQ_TEST_BIT] = st.clockBytes[4][`DAY_FREQ_TEST_BIT];
    end

    // Load hold released: copy the visible time into the counters
    next_st.prevLoadHold = st.clockBytes[0][`CTRL_LOAD_HOLD_BIT];
    if (loadRelease) begin
      for (i = 0; i < 7; i++) begin
        next_st.counters[i] = timeField(st.clockBytes[i+1], i);
      end
      next_st.prescale = 32'h0;
    end

    // Write cycle: data is taken while active and stored on the first releasing edge
    next_st.wrActive = writeCond;
    if (writeCond) begin
      next_st.wrAddr = addr;
      next_st.wrData = dataIn;
    end
    if (st.wrActive && !writeCond && !deselected) begin
      if (st.wrAddr >= `CLOCK_CONTROL) begin
        next_st.clockBytes[st.wrAddr[2:0]] = st.wrData;
      end else begin
        memWe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st.pwr          <= rtc_ram_pkg::PWR_RESTORE;
      st.pwrTimer     <= 32'h0;
      st.alertLow     <= 1'b0;
      st.prescale     <= 32'h0;
      st.clockBytes   <= {`RESET_CLOCK_BYTE, `RESET_CALENDAR_BYTE, `RESET_CALENDAR_BYTE,
                          `RESET_CALENDAR_BYTE, `RESET_CLOCK_BYTE, `RESET_CLOCK_BYTE,
                          `RESET_CLOCK_BYTE, `RESET_CLOCK_BYTE};
      st.counters     <= {`RESET_CLOCK_BYTE, `RESET_CALENDAR_BYTE, `RESET_CALENDAR_BYTE,
                          `RESET_CALENDAR_BYTE, `RESET_CLOCK_BYTE, `RESET_CLOCK_BYTE,
                          `RESET_CLOCK_BYTE};
      st.prevLoadHold <= 1'b0;
      st.wrActive     <= 1'b0;
      st.wrAddr       <= 13'h0000;
      st.wrData       <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // Storage array and registered read path
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[st.wrAddr] <= st.wrData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataOut <= 8'h00;
    end else if (isClockAddr) begin
      dataOut <= st.clockBytes[addr[2:0]];
    end else begin
      dataOut <= mem[addr];
    end
  end

  assign dataOe_n           = !(selected && !outputDrive_n && storeStrobe_n);
  assign powerFailAlertOut  = 1'b0;
  assign powerFailAlertOe_n = !st.alertLow;

endmodule // battery_backed_clock_ram_port

// ===== src/rtc_ram_map.svh
// Address map, field positions, reset values and timing counts of the clock RAM port
`ifndef RTC_RAM_MAP_SVH
`define RTC_RAM_MAP_SVH
`define ADDR_W              13
`define CLOCK_CONTROL       13'h1FF8
`define SECONDS_BCD         13'h1FF9
`define MINUTES_BCD         13'h1FFA
`define HOURS_BCD           13'h1FFB
`define WEEKDAY_BCD         13'h1FFC
`define DATE_BCD            13'h1FFD
`define MONTH_BCD           13'h1FFE
`define YEAR_BCD            13'h1FFF
`define CTRL_LOAD_HOLD_BIT  7
`define CTRL_SNAP_HOLD_BIT  6
`define CTRL_CALIB_SIGN_BIT 5
`define SEC_OSC_HALT_BIT    7
`define DAY_FREQ_TEST_BIT   6
`define MAX_SECONDS         8'h59
`define MAX_MINUTES         8'h59
`define MAX_HOURS           8'h23
`define MAX_WEEKDAY         8'h07
`define MAX_MONTH           8'h12
`define MAX_YEAR            8'h99
`define MIN_ONE             8'h01
`define MIN_ZERO            8'h00
`define RESET_CLOCK_BYTE    8'h00
`define RESET_CALENDAR_BYTE 8'h01
`define CLK_PERIOD_NS       25
`define CLK_HZ              40000000
`define ALERT_DELAY_MIN_NS  10000
`define ALERT_DELAY_MAX_NS  40000
`define ALERT_DELAY_CYCLES  ((`ALERT_DELAY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESTORE_DELAY_NS    1000000
`define RESTORE_CYCLES_DEF  ((`RESTORE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== src/rtc_ram_pkg.sv
// Types shared by the clock RAM port
package rtc_ram_pkg;
  typedef enum logic [1:0] {
    PWR_OK      = 2'h0,
    PWR_ALERT   = 2'h1,
    PWR_DESEL   = 2'h3,
    PWR_RESTORE = 2'h2
  } power_e;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    power_e          pwr;
    logic [31:0]     pwrTimer;
    logic            alertLow;
    logic [31:0]     prescale;
    logic [7:0][7:0] clockBytes;
    logic [6:0][7:0] counters;
    logic            prevLoadHold;
    logic            wrActive;
    logic [12:0]     wrAddr;
    logic [7:0]      wrData;
  } state_s;
endpackage

// ===== verification/rtc_port_host.sv
// Host bus controller model driving byte-wide memory cycles
`timescale 1ns/1ps
module rtc_port_host (
  input  wire logic        clk,
  output      logic [12:0] addr,
  output      logic [7:0]  dataIn,
  input  wire logic [7:0]  dataOut,
  input  wire logic        dataOe_n,
  output      logic        chipSelectA_n,
  output      logic        chipSelectB,
  output      logic        outputDrive_n,
  output      logic        storeStrobe_n
);
  initial begin
    addr = 13'h0000;
    dataIn = 8'h00;
    chipSelectA_n = 1'b1;
    chipSelectB = 1'b0;
    outputDrive_n = 1'b1;
    storeStrobe_n = 1'b1;
  end

  // endBy picks the edge that closes the write: 0 strobe, 1 select A, 2 select B
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input int endBy);
    @(posedge clk);
    #2;
    addr = a;
    dataIn = d;
    outputDrive_n = 1'b1;
    chipSelectA_n = 1'b0;
    chipSelectB = 1'b1;
    storeStrobe_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    if (endBy == 1) chipSelectA_n = 1'b1;
    else if (endBy == 2) chipSelectB = 1'b0;
    else storeStrobe_n = 1'b1;
    @(posedge clk);
    #2;
    chipSelectA_n = 1'b1;
    chipSelectB = 1'b0;
    storeStrobe_n = 1'b1;
    dataIn = ~d;
  endtask

  // Read cycle turned into a write by a falling strobe while the outputs are on
  task automatic rdThenWr(input logic [12:0] a, input logic [7:0] d, output logic oeRd_n,
                          output logic oeWr_n);
    @(posedge clk);
    #2;
    addr = a;
    dataIn = d;
    chipSelectA_n = 1'b0;
    chipSelectB = 1'b1;
    outputDrive_n = 1'b0;
    @(posedge clk);
    #2;
    oeRd_n = dataOe_n;
    storeStrobe_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    oeWr_n = dataOe_n;
    storeStrobe_n = 1'b1;
    @(posedge clk);
    #2;
    chipSelectA_n = 1'b1;
    chipSelectB = 1'b0;
    outputDrive_n = 1'b1;
    dataIn = ~d;
  endtask

  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic oe_n);
    @(posedge clk);
    #2;
    addr = a;
    chipSelectA_n = 1'b0;
    chipSelectB = 1'b1;
    outputDrive_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    d = dataOut;
    oe_n = dataOe_n;
    #1;
    chipSelectA_n = 1'b1;
    chipSelectB = 1'b0;
    outputDrive_n = 1'b1;
  endtask
endmodule // rtc_port_host

// ===== verification/rtc_port_sva.sv
// Port timing checks of the clock RAM port
`timescale 1ns/1ps
module rtc_port_chk #(
  parameter int unsigned SECOND_CYCLES  = 20,
  parameter int unsigned RESTORE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dataOe_n,
  input wire logic chipSelectA_n,
  input wire logic chipSelectB,
  input wire logic outputDrive_n,
  input wire logic storeStrobe_n,
  input wire logic supplyBelowTrip,
  input wire logic powerFailAlertOut,
  input wire logic powerFailAlertOe_n
);
  int  belowCnt;
  int  okCnt;
  wire readCond = !chipSelectA_n && chipSelectB && !outputDrive_n && storeStrobe_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      belowCnt <= 0;
      okCnt <= 0;
    end else begin
      belowCnt <= supplyBelowTrip ? (belowCnt < 999 ? belowCnt + 1 : belowCnt) : 0;
      okCnt <= (belowCnt >= 400) ? 0 : (okCnt < 999 ? okCnt + 1 : okCnt);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence sTrip;
    !supplyBelowTrip ##1 supplyBelowTrip;
  endsequence
  sequence sOpenRead;
    readCond && okCnt >= int'(RESTORE_CYCLES) + 6 && belowCnt < 398;
  endsequence

  AST_ALERT_SET: assert property (sTrip |=> !powerFailAlertOe_n) else $error("alert late");
  AST_ALERT_FREE: assert property (!supplyBelowTrip |=> powerFailAlertOe_n) else $error("alert stuck");
  AST_ALERT_LEVEL: assert property (powerFailAlertOe_n || powerFailAlertOut == 1'b0) else $error("alert high");
  AST_DESELECT: assert property (belowCnt > 402 |-> dataOe_n) else $error("driven when deselected");
  AST_STROBE_OFF: assert property (!storeStrobe_n |-> dataOe_n) else $error("driven in write");
  AST_IDLE_OFF: assert property (chipSelectA_n || !chipSelectB || outputDrive_n |-> dataOe_n) else $error("idle drive");
  AST_RESTORE_SHUT: assert property (okCnt < int'(RESTORE_CYCLES) |-> dataOe_n) else $error("early drive");
  AST_READ_OPEN: assert property (sOpenRead |-> !dataOe_n) else $error("read not driven");
endmodule // rtc_port_chk

bind battery_backed_clock_ram_port rtc_port_chk #(
  .SECOND_CYCLES(SECOND_CYCLES), .RESTORE_CYCLES(RESTORE_CYCLES)
) i_chk (
  .clk(clk), .nrst(nrst), .dataOe_n(dataOe_n), .chipSelectA_n(chipSelectA_n), .chipSelectB(chipSelectB),
  .outputDrive_n(outputDrive_n), .storeStrobe_n(storeStrobe_n), .supplyBelowTrip(supplyBelowTrip),
  .powerFailAlertOut(powerFailAlertOut), .powerFailAlertOe_n(powerFailAlertOe_n)
);

// ===== verification/tb_battery_backed_clock_ram_port.sv
// Self-checking bench of the clock RAM port
`timescale 1ns/1ps
`include "rtc_ram_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %0h expected %0h", $time, g, e); end end
module tb_battery_backed_clock_ram_port;
  localparam int unsigned REST = 8;
  logic        clk, nrst, dataOe_n, chipSelectA_n, chipSelectB, outputDrive_n, storeStrobe_n;
  logic        supplyBelowTrip, powerFailAlertOut, powerFailAlertOe_n, rdOe_n, wrOe_n;
  logic [12:0] addr;
  logic [7:0]  dataIn, dataOut, rdData, s0;
  int          n_mismatch, check_count;
  logic [7:0]  setVal [8] = '{8'h00, 8'h58, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0]  rollVal [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  // Open-drain alert line with its pull-up
  wire         alertPin = powerFailAlertOe_n ? 1'b1 : powerFailAlertOut;

  battery_backed_clock_ram_port #(.SECOND_CYCLES(20), .RESTORE_CYCLES(REST)) i_dut (
    .clk(clk), .nrst(nrst), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .chipSelectA_n(chipSelectA_n), .chipSelectB(chipSelectB), .outputDrive_n(outputDrive_n),
    .storeStrobe_n(storeStrobe_n), .supplyBelowTrip(supplyBelowTrip),
    .powerFailAlertOut(powerFailAlertOut), .powerFailAlertOe_n(powerFailAlertOe_n));
  rtc_port_host i_host (
    .clk(clk), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .chipSelectA_n(chipSelectA_n), .chipSelectB(chipSelectB), .outputDrive_n(outputDrive_n),
    .storeStrobe_n(storeStrobe_n));

  function automatic int bcd(input logic [7:0] v);
    return v[7:4] * 10 + v[3:0];
  endfunction

  task automatic chkRd(input logic [12:0] a, input logic [7:0] e);
    i_host.rd(a, rdData, rdOe_n);
    `CHK(rdOe_n, 1'b0)
    `CHK(rdData, e)
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    supplyBelowTrip = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    #2;
    nrst = 1'b1;
    repeat (REST + 8) @(posedge clk);
    for (int i = 0; i < 3; i++) i_host.wr(13'(13'h1FF5 + i), 8'(8'hA0 + i), i);
    for (int i = 0; i < 3; i++) chkRd(13'(13'h1FF5 + i), 8'(8'hA0 + i));
    i_host.rdThenWr(13'h0200, 8'h3C, rdOe_n, wrOe_n);
    `CHK(rdOe_n, 1'b0)
    `CHK(wrOe_n, 1'b1)
    chkRd(13'h0200, 8'h3C);
    i_host.wr(`CLOCK_CONTROL, 8'h80, 0);
    for (int i = 1; i < 8; i++) i_host.wr(13'(`CLOCK_CONTROL + i), setVal[i], 0);
    for (int i = 1; i < 8; i++) chkRd(13'(`CLOCK_CONTROL + i), setVal[i]);
    i_host.wr(`CLOCK_CONTROL, 8'h00, 0);
    repeat (22) @(posedge clk);
    chkRd(`SECONDS_BCD, 8'h59);
    repeat (20) @(posedge clk);
    for (int i = 1; i < 8; i++) chkRd(13'(`CLOCK_CONTROL + i), rollVal[i]);
    i_host.wr(`CLOCK_CONTROL, 8'h65, 0);
    chkRd(`CLOCK_CONTROL, 8'h65);
    i_host.rd(`SECONDS_BCD, s0, rdOe_n);
    repeat (45) @(posedge clk);
    chkRd(`SECONDS_BCD, s0);
    i_host.wr(`CLOCK_CONTROL, 8'h00, 0);
    repeat (25) @(posedge clk);
    i_host.rd(`SECONDS_BCD, rdData, rdOe_n);
    `CHK(1'(bcd(rdData) - bcd(s0) >= 3), 1'b1)
    i_host.wr(`CLOCK_CONTROL, 8'h80, 0);
    i_host.wr(`SECONDS_BCD, 8'h90, 0);
    i_host.wr(`CLOCK_CONTROL, 8'h00, 0);
    repeat (50) @(posedge clk);
    chkRd(`SECONDS_BCD, 8'h90);
    i_host.wr(13'h0100, 8'hA5, 0);
    supplyBelowTrip = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    `CHK(alertPin, 1'b0)
    chkRd(13'h0100, 8'hA5);
    repeat (400) @(posedge clk);
    i_host.wr(13'h0100, 8'h5A, 0);
    i_host.rd(13'h0100, rdData, rdOe_n);
    `CHK(rdOe_n, 1'b1)
    supplyBelowTrip = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    `CHK(alertPin, 1'b1)
    repeat (REST + 8) @(posedge clk);
    chkRd(13'h0100, 8'hA5);
    chkRd(13'h1FF5, 8'hA0);
    end_of_test();
  end
endmodule // tb_battery_backed_clock_ram_port
